// >>> core/fbwp_regs.svh
`ifndef FBWP_REGS_SVH
`define FBWP_REGS_SVH

// Register byte offsets
`define FBWP_OFS_STATUS    8'h00
`define FBWP_OFS_FUNCTION  8'h04
`define FBWP_OFS_CMD       8'h08
`define FBWP_OFS_RESULT    8'h0c
`define FBWP_OFS_READPAR   8'h10

// Status and function register fields
`define FBWP_ST_WIP        0
`define FBWP_ST_WEL        1
`define FBWP_ST_BP_LO      2
`define FBWP_ST_BP_HI      5
`define FBWP_ST_QUAD_EN    6
`define FBWP_ST_WR_DIS     7
`define FBWP_FN_BOTTOM     1

// Command word fields
`define FBWP_CMD_OP_HI     7
`define FBWP_CMD_OP_LO     0
`define FBWP_CMD_DATA_HI   15
`define FBWP_CMD_DATA_LO   8
`define FBWP_CMD_BLK_HI    22
`define FBWP_CMD_BLK_LO    16

// Reset values
`define FBWP_RST_STATUS    8'h00
`define FBWP_RST_READPAR   8'h00

// Opcodes
`define FBWP_OP_WR_EN      8'h06
`define FBWP_OP_WRDI       8'h04
`define FBWP_OP_SR_WRITE   8'h01
`define FBWP_OP_RDPAR_FREE 8'hc0
`define FBWP_OP_RDPAR      8'h63
`define FBWP_OP_PP         8'h02
`define FBWP_OP_PPQ_A      8'h32
`define FBWP_OP_PPQ_B      8'h38
`define FBWP_OP_SER_A      8'hd7
`define FBWP_OP_SER_B      8'h20
`define FBWP_OP_BER32      8'h52
`define FBWP_OP_BER64      8'hd8
`define FBWP_OP_ERASE_ALL_A 8'hc7
`define FBWP_OP_ERASE_ALL_B 8'h60

// Array geometry
`define FBWP_NUM_BLOCKS    8'h80

`endif

// >>> core/fbwp_pkg.sv
package fbwp_pkg;
  `include "fbwp_regs.svh"

  typedef enum logic [2:0] {
    FBWP_RES_NONE,
    FBWP_RES_OK,
    FBWP_RES_NO_WEL,
    FBWP_RES_LOCKED,
    FBWP_RES_PROTECTED,
    FBWP_RES_UNKNOWN
  } fbwp_result_e;

  typedef struct packed {
    logic       start;
    logic [7:0] opcode;
    logic [6:0] block;
  } fbwp_op_s;

  typedef struct packed {
    logic wp_func_en;
    logic hold_func_en;
    logic quad_io_en;
  } fbwp_pins_s;
endpackage

// >>> core/fbwp_top.sv
`timescale 1ns/1ps
// Function
// - Volatile read-parameter opcode C0h is accepted without write-enable.
// - Program or erase aimed at the protected region is inhibited.
// - Whole-array erase is ignored unless all four protect bits are zero.
// - Status-write-disable zero: status writes allowed whatever the pin level.
// - Disable one, quad-enable zero and pin low: protection bits read-only, status write ignored.
// - Disable one and pin high: status writes still accepted.
// - Quad-enable zero: protect and hold pins keep control functions.
// - Quad-enable one: those pins become data lines two and three.
// - Top area: code n in 1..7 protects highest 2^(n-1) blocks.
// - Bottom area: code n in 1..7 protects lowest 2^(n-1) blocks.
// - Standard table: top protect bit set protects all 128 blocks.
// - Optional table: codes 8..13 protect 96..127 blocks, 14-15 all.
// - Area is top by default; bottom select is one-time settable.
// - Status write needs the write-enable latch set, else rejected.
module fbwp_top
  import fbwp_pkg::*;
#(
  parameter bit OPT_TABLE = 1'b0,
  parameter int ADDR_W    = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              wp_pin,
  output fbwp_op_s               op_req,
  output fbwp_pins_s             pin_mode
);

  logic [7:0]   status;
  logic         bottom_sel;
  logic [7:0]   read_params;
  fbwp_result_e result;
  logic         wp_s1;
  logic         wp_s2;
  logic         wp_s3;
  logic         wp_level;

  logic [3:0] bp;
  logic       wel;
  logic       quad_enable;
  logic       status_write_disable;
  assign bp                   = status[`FBWP_ST_BP_HI:`FBWP_ST_BP_LO];
  assign wel                  = status[`FBWP_ST_WEL];
  assign quad_enable          = status[`FBWP_ST_QUAD_EN];
  assign status_write_disable = status[`FBWP_ST_WR_DIS];

  // Number of protected blocks for a code
  function automatic logic [7:0] prot_count(input logic [3:0] code, input bit opt);
    logic [7:0] n;
    n = 8'h00;
    if (code == 4'h0) begin
      n = 8'h00;
    end else if (!code[3]) begin
      n = 8'(8'h01 << (code[2:0] - 3'h1));
    end else if (!opt) begin
      n = `FBWP_NUM_BLOCKS;
    end else begin
      unique case (code[2:0])
        3'h0:    n = 8'h60;
        3'h1:    n = 8'h70;
        3'h2:    n = 8'h78;
        3'h3:    n = 8'h7c;
        3'h4:    n = 8'h7e;
        3'h5:    n = 8'h7f;
        default: n = `FBWP_NUM_BLOCKS;
      endcase
    end
    return n;
  endfunction

  function automatic logic is_protected(input logic [3:0] code, input logic bot,
                                        input logic [6:0] blk, input bit opt);
    logic [7:0] n;
    logic [8:0] reach;
    n     = prot_count(code, opt);
    reach = {2'b00, blk} + {1'b0, n};
    if (bot) begin
      return {1'b0, blk} < n;
    end
    return reach > 9'h07f;
  endfunction

  function automatic logic is_prog_erase(input logic [7:0] op);
    return op == `FBWP_OP_PP || op == `FBWP_OP_PPQ_A || op == `FBWP_OP_PPQ_B
        || op == `FBWP_OP_SER_A || op == `FBWP_OP_SER_B || op == `FBWP_OP_BER32
        || op == `FBWP_OP_BER64;
  endfunction

  // Bus decode
  logic       wr_fire;
  logic       rd_setup;
  logic       mapped;
  logic [7:0] addr8;
  assign addr8    = 8'(paddr);
  assign mapped   = addr8 == `FBWP_OFS_STATUS || addr8 == `FBWP_OFS_FUNCTION
                 || addr8 == `FBWP_OFS_CMD || addr8 == `FBWP_OFS_RESULT
                 || addr8 == `FBWP_OFS_READPAR;
  assign wr_fire  = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  logic       cmd_fire;
  logic [7:0] cmd_op;
  logic [7:0] cmd_data;
  logic [6:0] cmd_blk;
  assign cmd_fire = wr_fire && addr8 == `FBWP_OFS_CMD;
  assign cmd_op   = pwdata[`FBWP_CMD_OP_HI:`FBWP_CMD_OP_LO];
  assign cmd_data = pwdata[`FBWP_CMD_DATA_HI:`FBWP_CMD_DATA_LO];
  assign cmd_blk  = pwdata[`FBWP_CMD_BLK_HI:`FBWP_CMD_BLK_LO];

  logic sr_locked;
  logic pe_op;
  logic erase_all_op;
  // Lock only with pin low, pin is a control pin
  assign sr_locked    = status_write_disable && !quad_enable && !wp_level;
  assign pe_op        = is_prog_erase(cmd_op);
  assign erase_all_op = cmd_op == `FBWP_OP_ERASE_ALL_A || cmd_op == `FBWP_OP_ERASE_ALL_B;

  // Command outcome
  fbwp_result_e next_result;
  always_comb begin
    next_result = FBWP_RES_UNKNOWN;
    if (cmd_op == `FBWP_OP_WR_EN || cmd_op == `FBWP_OP_WRDI) begin
      next_result = FBWP_RES_OK;
    end else if (cmd_op == `FBWP_OP_RDPAR_FREE) begin
      next_result = FBWP_RES_OK;
    end else if (!wel && (cmd_op == `FBWP_OP_SR_WRITE || cmd_op == `FBWP_OP_RDPAR
                          || pe_op || erase_all_op)) begin
      next_result = FBWP_RES_NO_WEL;
    end else if (cmd_op == `FBWP_OP_SR_WRITE) begin
      next_result = sr_locked ? FBWP_RES_LOCKED : FBWP_RES_OK;
    end else if (cmd_op == `FBWP_OP_RDPAR) begin
      next_result = FBWP_RES_OK;
    end else if (pe_op) begin
      next_result = is_protected(bp, bottom_sel, cmd_blk, OPT_TABLE)
                  ? FBWP_RES_PROTECTED : FBWP_RES_OK;
    end else if (erase_all_op) begin
      next_result = (bp == 4'h0) ? FBWP_RES_OK : FBWP_RES_PROTECTED;
    end
  end

  // Pin sampler, change taken when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_s1    <= 1'b0;
      wp_s2    <= 1'b0;
      wp_s3    <= 1'b0;
      wp_level <= 1'b0;
    end else begin
      wp_s1 <= wp_pin;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
      if (wp_s2 == wp_s3) begin
        wp_level <= wp_s3;
      end
    end
  end

  // Status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `FBWP_RST_STATUS;
    end else if (cmd_fire) begin
      if (cmd_op == `FBWP_OP_WR_EN) begin
        status[`FBWP_ST_WEL] <= 1'b1;
      end else if (cmd_op == `FBWP_OP_WRDI) begin
        status[`FBWP_ST_WEL] <= 1'b0;
      end else if (cmd_op == `FBWP_OP_SR_WRITE && next_result == FBWP_RES_OK) begin
        status[`FBWP_ST_WR_DIS:`FBWP_ST_BP_LO] <= cmd_data[`FBWP_ST_WR_DIS:`FBWP_ST_BP_LO];
        status[`FBWP_ST_WEL]                   <= 1'b0;
      end else if ((pe_op || erase_all_op) && next_result == FBWP_RES_OK) begin
        status[`FBWP_ST_WEL] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bottom_sel <= 1'b0;
    end else if (wr_fire && addr8 == `FBWP_OFS_FUNCTION && pwdata[`FBWP_FN_BOTTOM]) begin
      bottom_sel <= 1'b1;
    end
  end

  // Volatile read parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_params <= `FBWP_RST_READPAR;
    end else if (cmd_fire && next_result == FBWP_RES_OK
                 && (cmd_op == `FBWP_OP_RDPAR_FREE || cmd_op == `FBWP_OP_RDPAR)) begin
      read_params <= cmd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= FBWP_RES_NONE;
    end else if (cmd_fire) begin
      result <= next_result;
    end
  end

  // Launch to the array engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_req <= '0;
    end else begin
      op_req.start <= cmd_fire && (pe_op || erase_all_op) && next_result == FBWP_RES_OK;
      if (cmd_fire) begin
        op_req.opcode <= cmd_op;
        op_req.block  <= cmd_blk;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (addr8)
        `FBWP_OFS_STATUS:   prdata <= {24'h00_0000, status};
        `FBWP_OFS_FUNCTION: prdata <= {30'h0000_0000, bottom_sel, 1'b0};
        `FBWP_OFS_RESULT:   prdata <= {29'h0000_0000, result};
        `FBWP_OFS_READPAR:  prdata <= {24'h00_0000, read_params};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pin_mode = {!quad_enable, !quad_enable, quad_enable};

  property p_rdpar_free;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_op == `FBWP_OP_RDPAR_FREE |=> result == FBWP_RES_OK
      && read_params == $past(cmd_data);
  endproperty
  a_rdpar_free: assert property (p_rdpar_free) else $error("C0h not accepted");
  property p_prot_block;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && pe_op && wel && is_protected(bp, bottom_sel, cmd_blk, OPT_TABLE)
      |=> !op_req.start && result == FBWP_RES_PROTECTED;
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("protected op ran");
  property p_erase_all_gate;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && erase_all_op && bp != 4'h0 |=> !op_req.start ##1 !op_req.start;
  endproperty
  a_erase_all_gate: assert property (p_erase_all_gate) else $error("erase all not ignored");
  property p_sr_free;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_op == `FBWP_OP_SR_WRITE && wel && !status_write_disable
      |=> status[7:2] == $past(cmd_data[7:2]) && !wel;
  endproperty
  a_sr_free: assert property (p_sr_free) else $error("status write lost");
  property p_sr_lock;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_op == `FBWP_OP_SR_WRITE && status_write_disable && !quad_enable && !wp_level
      |=> $stable(status[7:2]) && result != FBWP_RES_OK;
  endproperty
  a_sr_lock: assert property (p_sr_lock) else $error("locked status changed");
  property p_sr_wphi;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_op == `FBWP_OP_SR_WRITE && wel && status_write_disable && wp_level
      |=> status[7:2] == $past(cmd_data[7:2]);
  endproperty
  a_sr_wphi: assert property (p_sr_wphi) else $error("pin high write refused");
  property p_ctl_pins;
    @(posedge pclk) disable iff (!presetn)
    !quad_enable |-> pin_mode.wp_func_en && pin_mode.hold_func_en && !pin_mode.quad_io_en;
  endproperty
  a_ctl_pins: assert property (p_ctl_pins) else $error("control pins lost");
  property p_quad_pins;
    @(posedge pclk) disable iff (!presetn)
    quad_enable |-> pin_mode.quad_io_en && !pin_mode.wp_func_en && !pin_mode.hold_func_en;
  endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("quad lines off");
  property p_top_one;
    @(posedge pclk) disable iff (!presetn)
    op_req.start && !bottom_sel && !bp[3] && bp != 4'h0 |-> $past(bp) == bp
      && {1'b0, op_req.block} < 8'(8'h80 - (8'h01 << (bp[2:0] - 3'h1)));
  endproperty
  a_top_one: assert property (p_top_one) else $error("top region breached");
  property p_bot_one;
    @(posedge pclk) disable iff (!presetn)
    op_req.start && bottom_sel && !bp[3] && bp != 4'h0
      |-> {1'b0, op_req.block} >= 8'(8'h01 << (bp[2:0] - 3'h1));
  endproperty
  a_bot_one: assert property (p_bot_one) else $error("bottom region breached");
  property p_full;
    @(posedge pclk) disable iff (!presetn)
    bp[3] && (!OPT_TABLE || bp[2:1] == 2'b11) |-> !op_req.start || $changed(bp);
  endproperty
  a_full: assert property (p_full) else $error("full protect breached");
  property p_opt_eight;
    @(posedge pclk) disable iff (!presetn)
    OPT_TABLE && bp == 4'h8 && !bottom_sel && op_req.start && $stable(bp)
      |-> op_req.block < 7'h20;
  endproperty
  a_opt_eight: assert property (p_opt_eight) else $error("optional code wrong");
  property p_bottom_otp;
    @(posedge pclk) disable iff (!presetn)
    bottom_sel |=> bottom_sel [*2];
  endproperty
  a_bottom_otp: assert property (p_bottom_otp) else $error("bottom select cleared");
  property p_need_wel;
    @(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_op == `FBWP_OP_SR_WRITE && !wel
      |=> result == FBWP_RES_NO_WEL && $stable(status);
  endproperty
  a_need_wel: assert property (p_need_wel) else $error("write without enable");
endmodule

// >>> test/fbwp_host_model.sv
`timescale 1ns/1ps
module fbwp_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One bus transfer, held until pready is seen high or 50 cycles pass
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// >>> test/flash_block_write_protection_tb_top.sv
`timescale 1ns/1ps
`include "fbwp_regs.svh"
module flash_block_write_protection_tb_top;
  import fbwp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, wp_pin, pready, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] prdata_d [2];
  logic        pslverr_d [2];
  logic        pready_d [2];
  fbwp_op_s    op_d [2];
  fbwp_pins_s  pm_d [2];
  int          err_count, check_count, sel;
  bit          ok;
  logic [7:0]  ops [7] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8};
  logic [6:0]  blk;

  assign prdata = prdata_d[sel];
  assign pslverr = pslverr_d[sel];
  assign pready = pready_d[0] & pready_d[1];

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  for (genvar g = 0; g < 2; g++) begin : g_dut
    fbwp_top #(.OPT_TABLE(g == 1), .ADDR_W(8)) u_fbwp_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready_d[g]), .prdata(prdata_d[g]),
      .pslverr(pslverr_d[g]), .wp_pin(wp_pin), .op_req(op_d[g]), .pin_mode(pm_d[g]));
  end

  fbwp_host_model u_fbwp_host_model (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    u_fbwp_host_model.xfer(wr, a, d, q, e, ok);
    if (!ok) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic rd2(input logic [7:0] a, input logic [31:0] x0, input logic [31:0] x1);
    sel = 0;
    bus(1'b0, a, 32'h0);
    chk(q, x0);
    sel = 1;
    bus(1'b0, a, 32'h0);
    chk(q, x1);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic [6:0] b,
                     input fbwp_result_e r0, input fbwp_result_e r1, input bit pe);
    bus(1'b1, `FBWP_OFS_CMD, {9'h0, b, d, op});
    #1;
    chk(op_d[0].start, pe && r0 == FBWP_RES_OK);
    chk(op_d[1].start, pe && r1 == FBWP_RES_OK);
    chk({op_d[0].opcode, op_d[0].block}, {op, b});
    chk({op_d[1].opcode, op_d[1].block}, {op, b});
    rd2(`FBWP_OFS_RESULT, r0, r1);
  endtask

  function automatic int cnt(int c, bit opt);
    int t[8] = '{96, 112, 120, 124, 126, 127, 128, 128};
    if (c == 0)
      return 0;
    if (c >= 8)
      return opt ? t[c-8] : 128;
    return 1 << (c - 1);
  endfunction

  function automatic fbwp_result_e res(int c, int b7, bit bot, bit opt);
    int n = cnt(c, opt);
    return (bot ? b7 < n : b7 >= 128 - n) ? FBWP_RES_PROTECTED : FBWP_RES_OK;
  endfunction

  task automatic wsr(input logic [7:0] d, input fbwp_result_e r);
    cmd(`FBWP_OP_WR_EN, 8'h00, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    cmd(`FBWP_OP_SR_WRITE, d, 7'h0, r, r, 1'b0);
  endtask

  initial begin
    presetn = 1'b0;
    wp_pin = 1'b0;
    sel = 0;
    err_count = 0;
    check_count = 0;
    void'($urandom(7));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd2(`FBWP_OFS_STATUS, 32'h0, 32'h0);
    rd2(`FBWP_OFS_FUNCTION, 32'h0, 32'h0);
    chk(pm_d[0], 3'b110);
    bus(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    $display("test reset and map done");
    // issued with no write-enable before it
    cmd(`FBWP_OP_RDPAR_FREE, 8'h55, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    rd2(`FBWP_OFS_READPAR, 32'h55, 32'h55);
    cmd(`FBWP_OP_RDPAR, 8'h0f, 7'h0, FBWP_RES_NO_WEL, FBWP_RES_NO_WEL, 1'b0);
    cmd(`FBWP_OP_SR_WRITE, 8'h3c, 7'h0, FBWP_RES_NO_WEL, FBWP_RES_NO_WEL, 1'b0);
    rd2(`FBWP_OFS_STATUS, 32'h0, 32'h0);
    cmd(`FBWP_OP_WR_EN, 8'h00, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    cmd(`FBWP_OP_RDPAR, 8'h0f, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    rd2(`FBWP_OFS_READPAR, 32'h0f, 32'h0f);
    cmd(`FBWP_OP_WRDI, 8'h00, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    rd2(`FBWP_OFS_STATUS, 32'h0, 32'h0);
    cmd(8'hab, 8'h00, 7'h0, FBWP_RES_UNKNOWN, FBWP_RES_UNKNOWN, 1'b0);
    $display("test write-enable done");
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 16; c++) begin
        wsr(8'(c << 2), FBWP_RES_OK);
        rd2(`FBWP_OFS_STATUS, c << 2, c << 2);
        for (int k = 0; k < 6; k++) begin
          blk = 7'($urandom);
          if (k < 4)
            blk = 7'((b ? cnt(c, k / 2) : 128 - cnt(c, k / 2)) - k % 2);
          cmd(`FBWP_OP_WR_EN, 8'h00, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
          cmd(ops[(c + k) % 7], 8'h00, blk, res(c, blk, b, 0), res(c, blk, b, 1), 1'b1);
          chk({op_d[1].opcode, op_d[1].block}, {ops[(c + k) % 7], blk});
        end
        cmd(`FBWP_OP_WR_EN, 8'h00, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
        cmd(c % 2 ? `FBWP_OP_ERASE_ALL_A : `FBWP_OP_ERASE_ALL_B, 8'h00, 7'h0,
            c ? FBWP_RES_PROTECTED : FBWP_RES_OK,
            c ? FBWP_RES_PROTECTED : FBWP_RES_OK, 1'b1);
      end
      bus(1'b1, `FBWP_OFS_FUNCTION, 32'h2);
      bus(1'b1, `FBWP_OFS_FUNCTION, 32'h0);
      rd2(`FBWP_OFS_FUNCTION, 32'h2, 32'h2);
      $display("test protection table pass %0d done", b);
    end
    wsr(8'h80, FBWP_RES_OK);
    wsr(8'h3c, FBWP_RES_LOCKED);
    rd2(`FBWP_OFS_STATUS, 32'h82, 32'h82);
    wp_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    // quad mode set with the pin high, then cleared by a status write accepted after the pin goes low
    cmd(`FBWP_OP_SR_WRITE, 8'hc0, 7'h0, FBWP_RES_OK, FBWP_RES_OK, 1'b0);
    rd2(`FBWP_OFS_STATUS, 32'hc0, 32'hc0);
    chk(pm_d[1], 3'b001);
    wp_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    wsr(8'h00, FBWP_RES_OK);
    chk(pm_d[0], 3'b110);
    $display("test status lock done");
    end_sim();
  end
endmodule
